/* src/cpcfg_pkg.sv */
package cpcfg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the two-wire bus
   localparam logic [7:0] REG_SWITCH_CFG = 8'h21;
   localparam logic [7:0] REG_MIN_SYS = 8'h22;
   localparam logic [7:0] REG_SYS_LIMIT = 8'h23;
   localparam logic [7:0] REG_BACKUP_SYS = 8'h24;
   localparam logic [7:0] REG_SENSE_STATUS = 8'h30;

   ////////////////////////////////////////////////////////////////////////////
   // Field widths and reset values
   localparam int MIN_SYSTEM_VOLTAGE_W = 3;
   localparam int LEVEL_W = 6;
   localparam int MODE_W = 4;
   localparam int RESULT_W = 2;
   localparam int CV_W = 13;
   localparam int SYNC_W = 6;
   localparam logic [7:0] RST_SWITCH_CFG = 8'h00;
   localparam logic [MIN_SYSTEM_VOLTAGE_W-1:0] RST_MIN_SYS = 3'h5;
   localparam logic [LEVEL_W-1:0] RST_SYS_LIMIT = 6'h0a;
   localparam logic [LEVEL_W-1:0] RST_BACKUP_SYS = 6'h0a;
   localparam logic [MODE_W-1:0] RST_MODE = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Operating modes and voltage scale of the minimum system setting
   localparam logic [MODE_W-1:0] MODE_SENSE_OK = 4'h0;
   localparam int MIN_SYSTEM_VOLTAGE_BASE_MV = 3000;
   localparam int MIN_SYSTEM_VOLTAGE_STEP_MV = 100;
   localparam int CV_MARGIN_MV = 200;

   // Battery switch configuration, bit 7 down to bit 0
   typedef struct packed {
      logic wd_switch_off;
      logic boost_mode_override;
      logic batt_sys_switch_force_off;
      logic remote_sense_detect_enable;
      logic external_switch_control_enable;
      logic unused_2;
      logic battery_removal_mask;
      logic factory_ship_mode;
   } cpcfg_switch_cfg_s;

   // Operating mode change request from the charger core
   typedef struct packed {
      logic valid;
      logic [MODE_W-1:0] mode;
   } cpcfg_mode_req_s;

   typedef enum {
      S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_WDATA, S_WACK, S_RDATA, S_RACK
   } cpcfg_i2c_state_e;

endpackage : cpcfg_pkg

/* src/cpcfg_sync.sv */
`timescale 1ns/1ns
module cpcfg_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,              // System clock
   input wire logic nrst,                 // Async reset, active low
   input wire logic [WIDTH-1:0] async_in, // Signals from outside the clock domain
   output logic [WIDTH-1:0] sync_out      // Synchronised copies
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Two flops; the first one feeds only the second
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule : cpcfg_sync

/* src/cpcfg_regs.sv */
// Operation
// R1 - Override permits boost mode despite disconnect high
// R2 - Disconnect high without override rejects mode changes
// R3 - Force-off bit holds battery switch open
// R4 - Remote sense detection only in mode zero
// R5 - Detection completion raises battery interrupt
// R6 - Detection outcome stored in two-bit status
// R7 - Enable bit selects external switch control
// R8 - Removal mask suppresses battery removal detection
// R9 - Writing one enters factory ship mode
// R10 - Removal or charger plug clears ship mode
// R11 - Minimum system code three bits, reset five
// R12 - Minimum system clamped below termination minus margin
// R13 - Input limit level six bits, reset 0x0a
// R14 - Backup system level six bits field
// R15 - Unused bits read zero, writes ignored
`timescale 1ns/1ns
module cpcfg_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h3c,     // Bus address, value arbitrary
   parameter logic [3:0] MODE_BOOST = 4'h9     // Mode code of boost operation
) (
   input wire logic ref_clk,                                  // 10 MHz clock
   input wire logic nrst,                                     // Async reset, low
   input wire logic scl_in,                                   // Bus clock pin
   input wire logic sda_in,                                   // Bus data pin level
   output logic sda_out,                                      // Bus data drive level
   output logic sda_oe,                                       // Bus data drive enable
   input wire logic battery_disconnect_input,                 // Disconnect pin
   input wire cpcfg_pkg::cpcfg_mode_req_s mode_req,           // Mode change request
   output logic [cpcfg_pkg::MODE_W-1:0] operating_mode,       // Current mode
   output logic mode_change_reject,                           // Request refused pulse
   input wire logic psm_switch_on,                            // State machine switch demand
   input wire logic ext_switch_ctrl,                          // External switch pin
   output logic battery_switch_on,                            // Battery switch closed
   output logic sense_detect_start,                           // Start detection pulse
   input wire logic sense_detect_done,                        // Detection finished
   input wire logic [cpcfg_pkg::RESULT_W-1:0] sense_result,   // Detection outcome
   output logic battery_interrupt,                            // Battery event pulse
   input wire logic battery_removed,                          // Removal comparator pin
   output logic battery_removal_detected,                     // Unmasked removal
   input wire logic charger_input_valid,                      // Valid charger pin
   output logic factory_ship_active,                          // Ship mode requested
   output logic wd_switch_off_en,                             // Watchdog opens switch
   input wire logic [cpcfg_pkg::CV_W-1:0] charge_term_mv,     // Termination voltage mV
   output logic [cpcfg_pkg::MIN_SYSTEM_VOLTAGE_W-1:0] min_system_voltage, // Clamped code
   output logic [cpcfg_pkg::LEVEL_W-1:0] system_input_limit_level, // Mode 1 level
   output logic [cpcfg_pkg::LEVEL_W-1:0] backup_system_level  // Modes 4, 7 level
);
   import cpcfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edges
   logic [SYNC_W-1:0] sync_s;
   logic [SYNC_W-1:0] prev_ff;
   logic scl_s, sda_s, disc_s, ext_s, rmv_s, chg_s;

   cpcfg_sync #(.WIDTH(SYNC_W)) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in({scl_in, sda_in, battery_disconnect_input, ext_switch_ctrl,
                 battery_removed, charger_input_valid}),
      .sync_out(sync_s)
   );

   assign {scl_s, sda_s, disc_s, ext_s, rmv_s, chg_s} = sync_s;

   // Previous synchronised levels for edge detection
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         prev_ff <= '0;
      else
         prev_ff <= sync_s;
   end

   logic scl_rise, scl_fall, start_det, stop_det, rmv_rise, chg_rise;
   assign scl_rise = scl_s & ~prev_ff[5];
   assign scl_fall = ~scl_s & prev_ff[5];
   assign start_det = scl_s & prev_ff[5] & prev_ff[4] & ~sda_s;
   assign stop_det = scl_s & prev_ff[5] & ~prev_ff[4] & sda_s;
   assign rmv_rise = rmv_s & ~prev_ff[1];
   assign chg_rise = chg_s & ~prev_ff[0];

   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   cpcfg_switch_cfg_s sw_cfg_ff;
   logic [MIN_SYSTEM_VOLTAGE_W-1:0] min_system_voltage_ff, min_system_voltage_eff_ff;
   logic [LEVEL_W-1:0] syslim_ff, backup_ff;
   logic [RESULT_W-1:0] result_ff;
   logic [7:0] rd_data, ptr_ff, wr_addr_ff, wr_data_ff, shift_ff, tx_ff;
   logic wr_en_ff;

   // Highest minimum system code not above termination minus margin
   function automatic logic [MIN_SYSTEM_VOLTAGE_W-1:0] limit_code(input logic [CV_W-1:0] cv);
      int lim;
      logic [MIN_SYSTEM_VOLTAGE_W-1:0] c;
      lim = int'(cv) - CV_MARGIN_MV;
      c = '0;
      for (int k = 0; k < (1 << MIN_SYSTEM_VOLTAGE_W); k++)
         if (lim >= MIN_SYSTEM_VOLTAGE_BASE_MV + k * MIN_SYSTEM_VOLTAGE_STEP_MV)
            c = MIN_SYSTEM_VOLTAGE_W'(k);
      return c;
   endfunction : limit_code

   logic [MIN_SYSTEM_VOLTAGE_W-1:0] lim_code;
   assign lim_code = limit_code(charge_term_mv);

   // Readback mux, unused bits and unmapped offsets read as zero
   // R15 - zero unused bits
   always_comb
   begin
      rd_data = 8'h00;
      case (ptr_ff)
         REG_SWITCH_CFG: rd_data = sw_cfg_ff;
         REG_MIN_SYS: rd_data = {5'h00, min_system_voltage_eff_ff};
         REG_SYS_LIMIT: rd_data = {2'h0, syslim_ff};
         REG_BACKUP_SYS: rd_data = {2'h0, backup_ff};
         REG_SENSE_STATUS: rd_data = {6'h00, result_ff};
         default: rd_data = 8'h00;
      endcase
   end

   logic sw_hit;
   assign sw_hit = wr_en_ff && (wr_addr_ff == REG_SWITCH_CFG);

   // Switch configuration; a bus write beats a same-cycle hardware clear
   // R9 - enter ship mode
   // R10 - self clear ship
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         sw_cfg_ff <= RST_SWITCH_CFG;
      else if (sw_hit)
         sw_cfg_ff <= {wr_data_ff[7:3], 1'b0, wr_data_ff[1:0]};
      else if (rmv_rise || chg_rise)
         sw_cfg_ff.factory_ship_mode <= 1'b0;
   end

   // Level registers; the clamp acts on readback and output, not storage
   // R11 - minimum system field
   // R13 - input limit field
   // R14 - backup level field
   // R12 - clamp to limit
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         min_system_voltage_ff <= RST_MIN_SYS;
         min_system_voltage_eff_ff <= RST_MIN_SYS;
         syslim_ff <= RST_SYS_LIMIT;
         backup_ff <= RST_BACKUP_SYS;
      end
      else
      begin
         if (wr_en_ff && wr_addr_ff == REG_MIN_SYS)
            min_system_voltage_ff <= wr_data_ff[MIN_SYSTEM_VOLTAGE_W-1:0];
         if (wr_en_ff && wr_addr_ff == REG_SYS_LIMIT)
            syslim_ff <= wr_data_ff[LEVEL_W-1:0];
         if (wr_en_ff && wr_addr_ff == REG_BACKUP_SYS)
            backup_ff <= wr_data_ff[LEVEL_W-1:0];
         min_system_voltage_eff_ff <= (min_system_voltage_ff > lim_code) ? lim_code : min_system_voltage_ff;
      end
   end

   a_clamp: assert property (p_clamp) else $error("min system code above limit"); // R12
   property p_clamp;
      @(posedge ref_clk) disable iff (!nrst)
      ##1 (min_system_voltage_eff_ff <= $past(lim_code)) && (min_system_voltage_eff_ff <= $past(min_system_voltage_ff));
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // Operating mode gate
   logic mode_ok;
   // R1 - boost despite disconnect
   // R2 - reject under disconnect
   assign mode_ok = !disc_s || (sw_cfg_ff.boost_mode_override && mode_req.mode == MODE_BOOST);

   logic [MODE_W-1:0] mode_ff;
   logic reject_ff;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_ff <= RST_MODE;
         reject_ff <= 1'b0;
      end
      else
      begin
         reject_ff <= mode_req.valid && !mode_ok;
         if (mode_req.valid && mode_ok)
            mode_ff <= mode_req.mode;
      end
   end

   a_boost: assert property (p_boost) else $error("boost change not taken"); // R1
   property p_boost;
      @(posedge ref_clk) disable iff (!nrst)
      mode_req.valid && disc_s && sw_cfg_ff.boost_mode_override && mode_req.mode == MODE_BOOST
      |=> mode_ff == MODE_BOOST && !reject_ff;
   endproperty

   a_reject: assert property (p_reject) else $error("mode changed under disconnect"); // R2
   property p_reject;
      @(posedge ref_clk) disable iff (!nrst)
      mode_req.valid && disc_s && !sw_cfg_ff.boost_mode_override
      |=> $stable(mode_ff) && reject_ff;
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // Battery switch and removal
   logic switch_ff, removal_ff;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         switch_ff <= 1'b0;
         removal_ff <= 1'b0;
      end
      else
      begin
         // R3 - force switch off
         // R7 - external control select
         switch_ff <= !sw_cfg_ff.batt_sys_switch_force_off &&
                      (sw_cfg_ff.external_switch_control_enable ? ext_s : psm_switch_on);
         // R8 - mask removal detection
         removal_ff <= rmv_s && !sw_cfg_ff.battery_removal_mask;
      end
   end

   a_force_off: assert property (p_force_off) else $error("switch on while forced off"); // R3
   property p_force_off;
      @(posedge ref_clk) disable iff (!nrst)
      sw_cfg_ff.batt_sys_switch_force_off |=> !switch_ff;
   endproperty

   a_ext: assert property (p_ext) else $error("external control not followed"); // R7
   property p_ext;
      @(posedge ref_clk) disable iff (!nrst)
      sw_cfg_ff.external_switch_control_enable && !sw_cfg_ff.batt_sys_switch_force_off
      |=> switch_ff == $past(ext_s);
   endproperty

   a_mask: assert property (p_mask) else $error("masked removal reported"); // R8
   property p_mask;
      @(posedge ref_clk) disable iff (!nrst)
      sw_cfg_ff.battery_removal_mask |=> !removal_ff;
   endproperty

   a_ship_clr: assert property (p_ship_clr) else $error("ship mode not cleared"); // R10
   property p_ship_clr;
      @(posedge ref_clk) disable iff (!nrst)
      (rmv_rise || chg_rise) && !sw_hit |=> !sw_cfg_ff.factory_ship_mode;
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // Remote sense detection; requests outside mode zero are dropped
   logic sense_req, busy_ff, start_ff, irq_ff;
   assign sense_req = sw_hit && wr_data_ff[4];

   // R4 - mode zero only
   // R5 - completion interrupt
   // R6 - store outcome
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy_ff <= 1'b0;
         start_ff <= 1'b0;
         irq_ff <= 1'b0;
         result_ff <= '0;
      end
      else
      begin
         start_ff <= sense_req && !busy_ff && mode_ff == MODE_SENSE_OK;
         irq_ff <= busy_ff && sense_detect_done;
         if (busy_ff && sense_detect_done)
         begin
            busy_ff <= 1'b0;
            result_ff <= sense_result;
         end
         else if (sense_req && mode_ff == MODE_SENSE_OK)
            busy_ff <= 1'b1;
      end
   end

   a_discard: assert property (p_discard) else $error("detection ran outside mode 0"); // R4
   property p_discard;
      @(posedge ref_clk) disable iff (!nrst)
      sense_req && !busy_ff && mode_ff != MODE_SENSE_OK |=> !busy_ff && !start_ff;
   endproperty

   sequence s_detect_finish;
      busy_ff && sense_detect_done;
   endsequence

   a_irq: assert property (p_irq) else $error("no single interrupt at completion"); // R5
   property p_irq;
      @(posedge ref_clk) disable iff (!nrst)
      s_detect_finish |=> irq_ff ##1 !irq_ff;
   endproperty

   a_result: assert property (p_result) else $error("outcome not stored"); // R6
   property p_result;
      @(posedge ref_clk) disable iff (!nrst)
      s_detect_finish |=> result_ff == $past(sense_result) && !busy_ff;
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire slave; data is changed after a falling clock edge, and released at a start or stop
   cpcfg_i2c_state_e state_ff;
   logic [3:0] cnt_ff;
   logic read_ff, drive_ff;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         read_ff <= 1'b0;
         drive_ff <= 1'b0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         wr_en_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end
      else
      begin
         wr_en_ff <= 1'b0;
         if (start_det)
         begin
            state_ff <= S_ADDR;
            cnt_ff <= 4'h0;
            drive_ff <= 1'b0;
         end
         else if (stop_det)
         begin
            state_ff <= S_IDLE;
            drive_ff <= 1'b0;
         end
         else if (scl_rise)
         begin
            case (state_ff)
               S_ADDR, S_PTR, S_WDATA:
               begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                  cnt_ff <= cnt_ff + 4'h1;
               end
               S_RACK: if (sda_s) state_ff <= S_IDLE;
               default: ;
            endcase
         end
         else if (scl_fall)
         begin
            case (state_ff)
               S_ADDR:
                  if (cnt_ff == 4'h8)
                  begin
                     if (shift_ff[7:1] == DEV_ADDR)
                     begin
                        state_ff <= S_AACK;
                        drive_ff <= 1'b1;
                        read_ff <= shift_ff[0];
                     end
                     else
                        state_ff <= S_IDLE;
                  end
               S_AACK, S_RACK:
                  if (read_ff)
                  begin
                     tx_ff <= rd_data;
                     drive_ff <= ~rd_data[7];
                     cnt_ff <= 4'h1;
                     ptr_ff <= ptr_ff + 8'h01;
                     state_ff <= S_RDATA;
                  end
                  else
                  begin
                     drive_ff <= 1'b0;
                     cnt_ff <= 4'h0;
                     state_ff <= S_PTR;
                  end
               S_PTR:
                  if (cnt_ff == 4'h8)
                  begin
                     ptr_ff <= shift_ff;
                     drive_ff <= 1'b1;
                     state_ff <= S_PACK;
                  end
               S_PACK, S_WACK:
               begin
                  drive_ff <= 1'b0;
                  cnt_ff <= 4'h0;
                  state_ff <= S_WDATA;
               end
               S_WDATA:
                  if (cnt_ff == 4'h8)
                  begin
                     wr_en_ff <= 1'b1;
                     wr_addr_ff <= ptr_ff;
                     wr_data_ff <= shift_ff;
                     ptr_ff <= ptr_ff + 8'h01;
                     drive_ff <= 1'b1;
                     state_ff <= S_WACK;
                  end
               S_RDATA:
                  if (cnt_ff == 4'h8)
                  begin
                     drive_ff <= 1'b0;
                     state_ff <= S_RACK;
                  end
                  else
                  begin
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     drive_ff <= ~tx_ff[6];
                     cnt_ff <= cnt_ff + 4'h1;
                  end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign sda_out = 1'b0;
   assign sda_oe = drive_ff;
   assign operating_mode = mode_ff;
   assign mode_change_reject = reject_ff;
   assign battery_switch_on = switch_ff;
   assign sense_detect_start = start_ff;
   assign battery_interrupt = irq_ff;
   assign battery_removal_detected = removal_ff;
   assign factory_ship_active = sw_cfg_ff.factory_ship_mode;
   assign wd_switch_off_en = sw_cfg_ff.wd_switch_off;
   assign min_system_voltage = min_system_voltage_eff_ff;
   assign system_input_limit_level = syslim_ff;
   assign backup_system_level = backup_ff;

endmodule : cpcfg_regs

/* verification/cpcfg_host_model.sv */
`timescale 1ns/1ns
module cpcfg_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h3c // Target address, value arbitrary
) (
   input wire logic ref_clk, // System clock
   input wire logic sda_w,   // Resolved data wire
   output logic scl,         // Bus clock, idle high
   output logic m_low        // High pulls data low
);
   initial
   begin
      scl = 1'b1;
      m_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Every change lands just after an edge so the device never sees a race
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask : hold
   // Data moves only while the clock is low; sampled at end of the high phase
   task automatic bit_x(input logic b, output logic r);
      m_low = ~b;
      hold(5);
      scl = 1'b1;
      hold(10);
      r = sda_w;
      scl = 1'b0;
      hold(5);
   endtask : bit_x
   // Also serves as repeated start from a low clock
   task automatic start;
      m_low = 1'b0;
      hold(5);
      scl = 1'b1;
      hold(5);
      m_low = 1'b1;
      hold(5);
      scl = 1'b0;
      hold(5);
   endtask : start
   task automatic stop;
      m_low = 1'b1;
      hold(5);
      scl = 1'b1;
      hold(5);
      m_low = 1'b0;
      hold(10);
   endtask : stop
   // Eight bits MSB first, then the ninth bit given by b9
   task automatic byte_x(input logic [7:0] d, input logic b9,
                         output logic [7:0] q, output logic r9);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], r);
         q[i] = r;
      end
      bit_x(b9, r9);
   endtask : byte_x
   ////////////////////////////////////////////////////////////////////////////
   // Register write; nak is high if any byte went unanswered
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic a;
      logic b;
      logic c;
      start();
      byte_x({DEV_ADDR, 1'b0}, 1'b1, q, a);
      byte_x(ptr, 1'b1, q, b);
      byte_x(d, 1'b1, q, c);
      stop();
      nak = a | b | c;
   endtask : wr
   // Pointer write, repeated start, one byte read closed by a NACK
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      start();
      byte_x({DEV_ADDR, 1'b0}, 1'b1, q, a);
      byte_x(ptr, 1'b1, q, a);
      start();
      byte_x({DEV_ADDR, 1'b1}, 1'b1, q, a);
      byte_x(8'hff, 1'b1, d, a);
      stop();
   endtask : rd
endmodule : cpcfg_host_model

/* verification/cpcfg_regs_tb.sv */
`timescale 1ns/1ns
module cpcfg_regs_tb;
   import cpcfg_pkg::*;
   localparam logic [3:0] BOOST = 4'h9;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, m_low, sda_oe, disc, psm, ext, done, removed, chg;
   logic bis, sds, bi, brd, fsa, rej, nak, wd;
   logic [1:0] res;
   logic [12:0] cv;
   cpcfg_mode_req_s mreq;
   logic [3:0] opm;
   logic [2:0] msv;
   logic [5:0] sil, bsl;
   logic [7:0] rv;
   int n_errors = 0;
   int num_checks = 0;
   int n_rej = 0;
   int n_start = 0;
   int n_int = 0;
   wire logic sda_w;
   // Open-drain wire with pull-up
   assign sda_w = ~(sda_oe | m_low);
   always #50 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////
   cpcfg_regs #(.MODE_BOOST(BOOST)) u_cpcfg_regs (.ref_clk(ref_clk), .nrst(nrst),
      .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
      .battery_disconnect_input(disc), .mode_req(mreq), .operating_mode(opm),
      .mode_change_reject(rej), .psm_switch_on(psm), .ext_switch_ctrl(ext),
      .battery_switch_on(bis), .sense_detect_start(sds), .sense_detect_done(done),
      .sense_result(res), .battery_interrupt(bi), .battery_removed(removed),
      .battery_removal_detected(brd), .charger_input_valid(chg),
      .factory_ship_active(fsa), .wd_switch_off_en(wd), .charge_term_mv(cv),
      .min_system_voltage(msv), .system_input_limit_level(sil),
      .backup_system_level(bsl));
   cpcfg_host_model u_cpcfg_host_model (.ref_clk(ref_clk), .sda_w(sda_w),
      .scl(scl), .m_low(m_low));
   // Pulses are counted, so their exact cycle does not matter to the checks
   always @(posedge ref_clk)
   begin
      if (rej === 1'b1) n_rej++;
      if (sds === 1'b1) n_start++;
      if (bi === 1'b1) n_int++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chb(input logic got, input logic exp);
      chk({7'h0, got}, {7'h0, exp});
   endtask : chb
   // Every write must be acknowledged in full
   task automatic w(input logic [7:0] ptr, input logic [7:0] d);
      u_cpcfg_host_model.wr(ptr, d, nak);
      chb(nak, 1'b0);
   endtask : w
   task automatic r(input logic [7:0] ptr, input logic [7:0] exp);
      u_cpcfg_host_model.rd(ptr, rv);
      chk(rv, exp);
   endtask : r
   task automatic req(input logic [3:0] m);
      mreq = {1'b1, m};
      cyc(1);
      mreq = '0;
      cyc(2);
   endtask : req
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // A hang ends the run as a failure
   initial
   begin
      repeat (90000) @(posedge ref_clk);
      n_errors++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {disc, psm, ext, done, removed, chg, res} = '0;
      mreq = '0;
      cv = 13'd4400;
      repeat (2) @(posedge ref_clk);
      #10;
      nrst = 1'b1;
      cyc(4);
      chk({5'h0, msv}, 8'h05);
      chk({2'h0, sil}, 8'h0a);
      r(REG_SWITCH_CFG, 8'h00);
      r(REG_MIN_SYS, 8'h05);
      r(REG_SYS_LIMIT, 8'h0a);
      r(REG_BACKUP_SYS, 8'h0a);
      $display("test reset done");
      // Field widths, reserved bits, unmapped place, foreign address
      w(REG_SYS_LIMIT, 8'hff);
      r(REG_SYS_LIMIT, 8'h3f);
      chk({2'h0, sil}, 8'h3f);
      w(REG_BACKUP_SYS, 8'hd5);
      r(REG_BACKUP_SYS, 8'h15);
      chk({2'h0, bsl}, 8'h15);
      w(8'h25, 8'hff);
      r(8'h25, 8'h00);
      w(REG_SWITCH_CFG, 8'h04);
      r(REG_SWITCH_CFG, 8'h00);
      u_cpcfg_host_model.start();
      u_cpcfg_host_model.byte_x(8'h50, 1'b1, rv, nak);
      u_cpcfg_host_model.stop();
      chb(nak, 1'b1);
      $display("test fields done");
      // Clamp follows the termination voltage; written code is kept
      w(REG_MIN_SYS, 8'hff);
      r(REG_MIN_SYS, 8'h07);
      cv = 13'd3500;
      cyc(2);
      r(REG_MIN_SYS, 8'h03);
      cv = 13'd3499;
      cyc(2);
      chk({5'h0, msv}, 8'h02);
      cv = 13'd4400;
      cyc(2);
      chk({5'h0, msv}, 8'h07);
      $display("test clamp done");
      // Mode changes under the disconnect input
      req(4'h4);
      chk({4'h0, opm}, 8'h04);
      disc = 1'b1;
      cyc(4);
      req(4'h1);
      req(BOOST);
      chk({4'h0, opm}, 8'h04);
      w(REG_SWITCH_CFG, 8'h40);
      req(BOOST);
      chk({4'h0, opm}, 8'h09);
      req(4'h1);
      chk(8'(n_rej), 8'h03);
      $display("test mode done");
      // Detection outside mode zero is dropped, inside it completes
      w(REG_SWITCH_CFG, 8'h50);
      cyc(4);
      chk(8'(n_start), 8'h00);
      disc = 1'b0;
      cyc(4);
      req(4'h0);
      w(REG_SWITCH_CFG, 8'h10);
      cyc(2);
      chk(8'(n_start), 8'h01);
      res = 2'b10;
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      cyc(2);
      chk(8'(n_int), 8'h01);
      r(REG_SENSE_STATUS, 8'h02);
      $display("test sense done");
      // Battery switch sources
      psm = 1'b1;
      cyc(2);
      chb(bis, 1'b1);
      w(REG_SWITCH_CFG, 8'h20);
      cyc(1);
      chb(bis, 1'b0);
      w(REG_SWITCH_CFG, 8'h08);
      cyc(4);
      chb(bis, 1'b0);
      ext = 1'b1;
      cyc(4);
      chb(bis, 1'b1);
      $display("test switch done");
      // Ship mode and removal mask
      w(REG_SWITCH_CFG, 8'h03);
      cyc(1);
      chb(fsa, 1'b1);
      removed = 1'b1;
      cyc(5);
      chb(brd, 1'b0);
      chb(fsa, 1'b0);
      w(REG_SWITCH_CFG, 8'h00);
      cyc(2);
      chb(brd, 1'b1);
      removed = 1'b0;
      w(REG_SWITCH_CFG, 8'h01);
      chb(fsa, 1'b1);
      chg = 1'b1;
      cyc(5);
      chb(fsa, 1'b0);
      // Top bit is stored and drives its output, bit 2 stays dropped
      w(REG_SWITCH_CFG, 8'h84);
      r(REG_SWITCH_CFG, 8'h80);
      chb(wd, 1'b1);
      $display("test ship done");
      wrap_up();
   end
endmodule : cpcfg_regs_tb
